// ==== lpe_pkg.sv ====
`default_nettype none

package lpe_pkg;

   // ---------------------------------------------------------------
   // controller states (three-bit register)
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_CONFIRM,
      ST_HOUSEKEEP,
      ST_GATE,
      ST_FROZEN,
      ST_EXIT
   } lpe_state_e;

   // ---------------------------------------------------------------
   // timing
   // ---------------------------------------------------------------
   localparam int unsigned CLK_PERIOD_NS = 4;
   localparam int unsigned CONFIRM_TIME_NS = 64;
   localparam int unsigned CONFIRM_CYCLES =
      (CONFIRM_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned GATE_CYCLES = 2;
   localparam int CNT_W = 5;
   localparam logic [CNT_W-1:0] CNT_RESET = 5'h00;
   localparam logic [CNT_W-1:0] CONFIRM_LAST =
      CNT_W'(CONFIRM_CYCLES - 1);
   localparam logic [CNT_W-1:0] GATE_LAST = CNT_W'(GATE_CYCLES - 1);
   localparam logic [2:0] SYNC_RESET = 3'h0;

   // ---------------------------------------------------------------
   // output bundle
   // ---------------------------------------------------------------
   typedef struct packed {
      logic wait_housekeeping;
      logic clock_gate;
      logic low_power_entry_signal;
      logic low_power_active;
   } lpe_ctrl_s;

   localparam lpe_ctrl_s CTRL_RESET = '{1'b0, 1'b0, 1'b0, 1'b0};

endpackage : lpe_pkg

`default_nettype wire

// ==== lpe_sync3.sv ====
`timescale 1ns/1ps
`default_nettype none

// ---------------------------------------------------------------
// three-stage pin synchroniser, output moves when stages 2 and 3 agree
// ---------------------------------------------------------------
module lpe_sync3 (
   // clock and reset
   input wire logic clk_sys_in,
   input wire logic resetn_in,
   // pin and result
   input wire logic pin_in,
   output logic level_out
);

   logic [2:0] sync_ff;
   logic [2:0] nxt_sync;
   logic level_ff;
   logic nxt_level;

   always_comb begin
      nxt_sync = {sync_ff[1:0], pin_in};
      nxt_level = level_ff;
      if (sync_ff[1] == sync_ff[2]) begin
         nxt_level = sync_ff[2];
      end
      if (!resetn_in) begin
         nxt_sync = lpe_pkg::SYNC_RESET;
         nxt_level = 1'b0;
      end
   end

   always_ff @(posedge clk_sys_in) begin
      sync_ff <= nxt_sync;
      level_ff <= nxt_level;
   end

   assign level_out = level_ff;

endmodule : lpe_sync3

`default_nettype wire

// ==== low_power_entry_fsm.sv ====
`timescale 1ns/1ps
`default_nettype none

module low_power_entry_fsm (
   // clock and reset
   input wire logic clk_sys_in,
   input wire logic resetn_in,
   // freeze request pin
   input wire logic freeze_req_in,
   // housekeeping handshake
   input wire logic housekeeping_done_in,
   output logic wait_housekeeping_out,
   // clock gating and entry macro
   output logic clock_gate_out,
   output logic low_power_entry_signal_out,
   // status
   output logic low_power_active_out,
   output logic [2:0] state_out
);

   // ---------------------------------------------------------------
   // request synchroniser
   // ---------------------------------------------------------------
   logic req_sync;

   lpe_sync3 u_req_sync (
      .clk_sys_in(clk_sys_in),
      .resetn_in(resetn_in),
      .pin_in(freeze_req_in),
      .level_out(req_sync)
   );

   // ---------------------------------------------------------------
   // state machine
   // ---------------------------------------------------------------
   lpe_pkg::lpe_state_e state_ff;
   lpe_pkg::lpe_state_e nxt_state;
   logic [lpe_pkg::CNT_W-1:0] cnt_ff;
   logic [lpe_pkg::CNT_W-1:0] nxt_cnt;
   lpe_pkg::lpe_ctrl_s ctrl_ff;
   lpe_pkg::lpe_ctrl_s nxt_ctrl;

   always_comb begin
      nxt_state = state_ff;
      nxt_cnt = cnt_ff + 5'h01;
      case (state_ff)
         lpe_pkg::ST_IDLE: begin
            nxt_cnt = lpe_pkg::CNT_RESET;
            if (req_sync) begin
               nxt_state = lpe_pkg::ST_CONFIRM;
            end
         end
         lpe_pkg::ST_CONFIRM: begin
            if (!req_sync) begin
               nxt_state = lpe_pkg::ST_IDLE;
            end else if (cnt_ff == lpe_pkg::CONFIRM_LAST) begin
               nxt_state = lpe_pkg::ST_HOUSEKEEP;
            end
         end
         lpe_pkg::ST_HOUSEKEEP: begin
            nxt_cnt = lpe_pkg::CNT_RESET;
            if (!req_sync) begin
               nxt_state = lpe_pkg::ST_EXIT;
            end else if (housekeeping_done_in) begin
               nxt_state = lpe_pkg::ST_GATE;
            end
         end
         lpe_pkg::ST_GATE: begin
            if (!req_sync) begin
               nxt_state = lpe_pkg::ST_EXIT;
            end else if (cnt_ff == lpe_pkg::GATE_LAST) begin
               nxt_state = lpe_pkg::ST_FROZEN;
            end
         end
         lpe_pkg::ST_FROZEN: begin
            if (!req_sync) begin
               nxt_state = lpe_pkg::ST_EXIT;
            end
         end
         lpe_pkg::ST_EXIT: begin
            nxt_state = lpe_pkg::ST_IDLE;
         end
         default: begin
            nxt_state = lpe_pkg::ST_IDLE;
         end
      endcase
      if (!resetn_in) begin
         nxt_state = lpe_pkg::ST_IDLE;
         nxt_cnt = lpe_pkg::CNT_RESET;
      end
   end

   // ---------------------------------------------------------------
   // registered outputs, decoded from next state
   // ---------------------------------------------------------------
   always_comb begin
      nxt_ctrl = lpe_pkg::CTRL_RESET;
      case (nxt_state)
         lpe_pkg::ST_HOUSEKEEP: begin
            nxt_ctrl.wait_housekeeping = 1'b1;
         end
         lpe_pkg::ST_GATE: begin
            nxt_ctrl.wait_housekeeping = 1'b1;
            nxt_ctrl.clock_gate = 1'b1;
         end
         lpe_pkg::ST_FROZEN: begin
            nxt_ctrl.wait_housekeeping = 1'b1;
            nxt_ctrl.clock_gate = 1'b1;
            nxt_ctrl.low_power_entry_signal = 1'b1;
            nxt_ctrl.low_power_active = 1'b1;
         end
         default: begin
            nxt_ctrl = lpe_pkg::CTRL_RESET;
         end
      endcase
   end

   always_ff @(posedge clk_sys_in) begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      ctrl_ff <= nxt_ctrl;
   end

   assign wait_housekeeping_out = ctrl_ff.wait_housekeeping;
   assign clock_gate_out = ctrl_ff.clock_gate;
   assign low_power_entry_signal_out = ctrl_ff.low_power_entry_signal;
   assign low_power_active_out = ctrl_ff.low_power_active;
   assign state_out = state_ff;

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk_sys_in);
   endclocking
   default disable iff (!resetn_in);

   sequence seq_confirmed;
      state_ff == lpe_pkg::ST_CONFIRM && req_sync &&
         cnt_ff == lpe_pkg::CONFIRM_LAST;
   endsequence

   sequence seq_done_seen;
      state_ff == lpe_pkg::ST_HOUSEKEEP && req_sync && housekeeping_done_in;
   endsequence

   sequence seq_gate_rise;
      $rose(clock_gate_out) && req_sync ##1 req_sync;
   endsequence

   AST_STATE_LEGAL: assert property (
      state_ff inside {lpe_pkg::ST_IDLE, lpe_pkg::ST_CONFIRM,
         lpe_pkg::ST_HOUSEKEEP, lpe_pkg::ST_GATE,
         lpe_pkg::ST_FROZEN, lpe_pkg::ST_EXIT})
      else $error("state register out of range");

   AST_IDLE_WAITS: assert property (
      state_ff == lpe_pkg::ST_IDLE && !req_sync |=>
         state_ff == lpe_pkg::ST_IDLE)
      else $error("left idle without request");

   AST_CONFIRM_FLAG: assert property (
      seq_confirmed |=> state_ff == lpe_pkg::ST_HOUSEKEEP &&
         wait_housekeeping_out)
      else $error("housekeeping request not raised after confirm");

   AST_NO_EARLY_FLAG: assert property (
      $rose(wait_housekeeping_out) |->
         $past(state_ff) == lpe_pkg::ST_CONFIRM)
      else $error("housekeeping request without confirm");

   AST_GATE_THEN_MACRO: assert property (
      seq_done_seen |=> clock_gate_out && !low_power_entry_signal_out)
      else $error("gating order wrong");

   AST_ACTIVE_AFTER_GATE: assert property (
      $rose(low_power_active_out) |->
         $past(clock_gate_out, 2) && $past(clock_gate_out))
      else $error("active before gating finished");

   AST_ACTIVE_HOLD: assert property (
      low_power_active_out && req_sync |=> low_power_active_out)
      else $error("active dropped while request held");

   AST_RELEASE: assert property (
      state_ff == lpe_pkg::ST_FROZEN && !req_sync |=>
         !low_power_active_out && !clock_gate_out &&
         !wait_housekeeping_out ##1 state_ff == lpe_pkg::ST_IDLE)
      else $error("release sequence wrong");

   AST_FLAG_HELD: assert property (
      state_ff inside {lpe_pkg::ST_HOUSEKEEP, lpe_pkg::ST_GATE,
         lpe_pkg::ST_FROZEN} |-> wait_housekeeping_out)
      else $error("housekeeping request dropped early");

   AST_MACRO_ORDER: assert property (
      $rose(low_power_entry_signal_out) |-> $past(clock_gate_out) &&
         low_power_active_out)
      else $error("entry macro driven before gating");

   AST_GATE_SETTLE: assert property (
      $rose(clock_gate_out) |-> !low_power_active_out ##1
         !low_power_active_out)
      else $error("active raised inside gate settle time");

   AST_FREEZE_ENTERED: assert property (
      seq_gate_rise |=> low_power_active_out &&
         state_ff == lpe_pkg::ST_FROZEN)
      else $error("freeze not entered after gate settle");

   AST_ABORT_EXIT: assert property (
      state_ff inside {lpe_pkg::ST_HOUSEKEEP, lpe_pkg::ST_GATE} &&
         !req_sync |=> state_ff == lpe_pkg::ST_EXIT &&
         !wait_housekeeping_out && !clock_gate_out)
      else $error("abort did not release outputs");

   AST_EXIT_IDLE: assert property (
      state_ff == lpe_pkg::ST_EXIT |=> state_ff == lpe_pkg::ST_IDLE)
      else $error("exit state did not return to idle");

endmodule : low_power_entry_fsm

`default_nettype wire

// ==== lpe_housekeeper.sv ====
`timescale 1ns/1ps
`default_nettype none

// ---------------------------------------------------------------
// user housekeeping logic model
// ---------------------------------------------------------------
module lpe_housekeeper (
   // clock and reset
   input wire logic clk_sys_in,
   input wire logic resetn_in,
   // mode
   input wire logic loopback_in,
   input wire logic [7:0] delay_in,
   // handshake
   input wire logic wait_housekeeping_in,
   output logic housekeeping_done_out
);
   logic [7:0] busy_ff;

   // shutdown work counted while the request stands
   always_ff @(posedge clk_sys_in) begin
      if (!resetn_in || !wait_housekeeping_in) begin
         busy_ff <= 8'h00;
      end else if (busy_ff != 8'hFF) begin
         busy_ff <= busy_ff + 8'h01;
      end
   end

   // done after the work, or looped straight back
   assign housekeeping_done_out = loopback_in ? wait_housekeeping_in :
      (wait_housekeeping_in && busy_ff >= delay_in);
endmodule : lpe_housekeeper

`default_nettype wire

// ==== tb.sv ====
`timescale 1ns/1ps
`default_nettype none

module tb;
   logic clk_sys_in = 1'b0;
   logic resetn_in = 1'b0;
   logic freeze_req_in = 1'b0;
   logic loopback = 1'b1;
   logic [7:0] hk_delay = 8'h00;
   logic done, wait_hk, gate, entry, active;
   logic [2:0] state;
   int error_cnt = 0;
   int total_checks = 0;
   int cyc = 0;
   int n;

   // ---------------------------------------------------------------
   // clock, design and user logic
   // ---------------------------------------------------------------
   initial begin
      forever #2 clk_sys_in = ~clk_sys_in;
   end

   low_power_entry_fsm dut (.clk_sys_in(clk_sys_in), .resetn_in(resetn_in),
      .freeze_req_in(freeze_req_in), .housekeeping_done_in(done),
      .wait_housekeeping_out(wait_hk), .clock_gate_out(gate),
      .low_power_entry_signal_out(entry), .low_power_active_out(active),
      .state_out(state));

   lpe_housekeeper user (.clk_sys_in(clk_sys_in), .resetn_in(resetn_in),
      .loopback_in(loopback), .delay_in(hk_delay),
      .wait_housekeeping_in(wait_hk), .housekeeping_done_out(done));

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   task automatic stop_test;
      $display("checks %0d errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : stop_test

   task automatic chk(input string what, input logic [7:0] exp,
                      input logic [7:0] got);
      total_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error %s expected %0h seen %0h", what, exp, got);
      end
   endtask : chk

   task automatic tick(input int k);
      repeat (k) @(posedge clk_sys_in);
      #1;
   endtask : tick

   task automatic chk_idle(input string what);
      chk(what, 8'h00, {4'h0, wait_hk, gate, entry, active});
      chk(what, 8'(lpe_pkg::ST_IDLE), {5'h00, state});
   endtask : chk_idle

   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task automatic t_glitch;
      @(posedge clk_sys_in);
      freeze_req_in <= 1'b1;
      tick(7);
      @(posedge clk_sys_in);
      freeze_req_in <= 1'b0;
      n = 0;
      repeat (30) begin
         tick(1);
         if (wait_hk !== 1'b0) n++;
      end
      chk("glitch_wait", 8'h00, 8'(n));
      chk_idle("glitch_idle");
   endtask : t_glitch

   task automatic t_entry(input logic lb, input logic [7:0] dly,
                          input int hold);
      @(posedge clk_sys_in);
      loopback <= lb;
      hk_delay <= dly;
      freeze_req_in <= 1'b1;
      #1;
      n = 0;
      while (wait_hk !== 1'b1 && n < 40) begin
         tick(1);
         n++;
      end
      chk("confirm", 8'h01, 8'(n >= lpe_pkg::CONFIRM_CYCLES && n < 40));
      chk("early", 8'h00, {6'h00, gate, active});
      repeat (dly) begin
         tick(1);
         chk("before_done", 8'h00, {6'h00, gate, active});
      end
      n = 0;
      while (active !== 1'b1 && n < 10) begin
         tick(1);
         n++;
      end
      chk("frozen", 8'h0F, {4'h0, wait_hk, gate, entry, active});
      chk("state", 8'(lpe_pkg::ST_FROZEN), {5'h00, state});
      n = 0;
      repeat (hold) begin
         tick(1);
         if (active !== 1'b1) n++;
      end
      chk("held", 8'h00, 8'(n));
      @(posedge clk_sys_in);
      freeze_req_in <= 1'b0;
      tick(6);
      chk_idle("released");
   endtask : t_entry

   task automatic t_abort;
      @(posedge clk_sys_in);
      loopback <= 1'b0;
      hk_delay <= 8'hC8;
      freeze_req_in <= 1'b1;
      tick(30);
      chk("hk_wait", 8'h01, {7'h00, wait_hk});
      @(posedge clk_sys_in);
      freeze_req_in <= 1'b0;
      tick(6);
      chk_idle("aborted");
   endtask : t_abort

   // ---------------------------------------------------------------
   // sequence and timeout
   // ---------------------------------------------------------------
   always @(posedge clk_sys_in) begin
      cyc++;
      if (cyc == 3000) begin
         error_cnt++;
         stop_test();
      end
   end

   initial begin
      tick(16);
      chk_idle("reset");
      @(posedge clk_sys_in);
      resetn_in <= 1'b1;
      tick(2);
      t_glitch();
      t_entry(1'b1, 8'h00, 40);
      t_entry(1'b1, 8'h00, 5);
      t_entry(1'b0, 8'h14, 20);
      t_abort();
      stop_test();
   end
endmodule : tb

`default_nettype wire
